// >>> rtl/memory_map_pkg.sv
// constants and types for the cpu memory space mapper
package memory_map_pkg;
	// ----------------------------------------
	// address windows
	// ----------------------------------------
	localparam logic [15:0] BANK_LO      = 16'h8000;
	localparam logic [15:0] FLASH_XD_TOP = 16'hDEFF;
	localparam logic [15:0] RADIO_LO     = 16'hDF00;
	localparam logic [15:0] SFR_MIR_LO   = 16'hDF80;
	localparam logic [15:0] SRAM_LO      = 16'hE000;
	localparam logic [15:0] RETAIN_LO    = 16'hF000;
	localparam logic [15:0] EXCL_LO      = 16'hFD56;
	localparam logic [15:0] EXCL_HI      = 16'hFEFF;
	localparam logic [4:0]  IDATA_PAGE   = 5'h1F;
	// ----------------------------------------
	// register locations and fields
	// ----------------------------------------
	localparam logic [7:0] SFR_BANKSEL   = 8'h9F;
	localparam logic [7:0] SFR_MEMCFG    = 8'hC7;
	localparam int         PRIM_LSB      = 0;
	localparam int         MIRR_LSB      = 4;
	localparam int         UNIF_BIT      = 6;
	localparam logic       UNIF_RST      = 1'b0;
	localparam logic [1:0] BANK_RST      = 2'h0;
	// core-internal registers, bit i is location 0x80+i
	localparam logic [127:0] CORE_SFR_MASK = 128'h0001_0001_0001_0000_0000_0000_0004_00BE;
	// ----------------------------------------
	// bus owner states
	// ----------------------------------------
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_FETCH = 3'b010,
		BUS_XDATA = 3'b100
	} bus_e;
endpackage

// >>> rtl/memory_space_mapper.sv
// cpu memory space mapper: four cpu spaces onto flash, sram and registers
`timescale 1ns/1ns
module memory_space_mapper
	import memory_map_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        small_flash_option,
	input  wire logic        large_flash_option,
	input  wire logic        deep_sleep_level_two,
	input  wire logic        deep_sleep_level_three,
	input  wire logic        code_req,
	input  wire logic [15:0] code_addr,
	input  wire logic        xd_req,
	input  wire logic        xd_we,
	input  wire logic [15:0] xd_addr,
	input  wire logic [7:0]  xd_wdata,
	input  wire logic        id_req,
	input  wire logic        id_indirect,
	input  wire logic [7:0]  id_addr,
	input  wire logic        sfr_req,
	input  wire logic        sfr_we,
	input  wire logic        sfr_bit,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic             code_grant,
	output logic             xd_grant,
	output logic             fetch_active,
	output logic             xdata_active,
	output logic             flash_en,
	output logic [16:0]      flash_addr,
	output logic             sram_en,
	output logic             sram_we,
	output logic [12:0]      sram_addr,
	output logic             radio_en,
	output logic [6:0]       radio_addr,
	output logic             sfr_xen,
	output logic [7:0]       sfr_xaddr,
	output logic             bus_we,
	output logic [7:0]       bus_wdata,
	output logic             bus_unmapped,
	output logic             id_sram_en,
	output logic [12:0]      id_sram_addr,
	output logic             id_reject,
	output logic             sfr_bit_ok,
	output logic [7:0]       sfr_rdata,
	output logic             unified_map_select,
	output logic [1:0]       bank_select_primary,
	output logic [1:0]       bank_select_mirror,
	output logic             sram_low_off,
	output logic             sram_excl_off
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		bus_e        bus;
		logic        munif;
		logic [1:0]  bank;
		logic [1:0]  opt_m;
		logic [1:0]  opt;
		logic        flash_en;
		logic [16:0] flash_addr;
		logic        sram_en;
		logic        sram_we;
		logic [12:0] sram_addr;
		logic        radio_en;
		logic [6:0]  radio_addr;
		logic        sfr_xen;
		logic [7:0]  sfr_xaddr;
		logic        bus_we;
		logic [7:0]  bus_wdata;
		logic        bus_unmapped;
		logic        id_sram_en;
		logic [12:0] id_sram_addr;
		logic        id_reject;
		logic        sfr_bit_ok;
		logic [7:0]  sfr_rdata;
		logic        sram_low_off;
		logic        sram_excl_off;
	} state_s;

	state_s s_q;
	state_s s_d;

	// register location seen through the external mirror window
	function automatic logic [7:0] mirror_sfr(input logic [15:0] a);
		mirror_sfr = {1'b1, a[6:0]};
	endfunction

	// ----------------------------------------
	// bus arbitration
	// ----------------------------------------
	// shared bus arbitration
	// data wins so a pending store is never starved by prefetch
	assign xd_grant   = xd_req;
	assign code_grant = code_req & ~xd_req;

	logic [15:0] a;
	logic        is_code;
	logic        big;
	logic        is_small;
	logic [1:0]  bank_eff;
	logic        in_sfr;
	logic        core_hit;
	logic [7:0]  wr_loc;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        sleep;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_d      = s_q;
		is_code  = code_grant;
		a        = xd_grant ? xd_addr : code_addr;
		is_small = s_q.opt[0];
		big      = s_q.opt[1];
		bank_eff = big ? s_q.bank : {1'b0, s_q.bank[0]};
		in_sfr   = (a >= SFR_MIR_LO) && (a < SRAM_LO);
		core_hit = CORE_SFR_MASK[a[6:0]];
		sleep    = deep_sleep_level_two | deep_sleep_level_three;
		// straps cross in through two flops
		s_d.opt_m = {large_flash_option, small_flash_option};
		s_d.opt   = s_q.opt_m;

		s_d.bus          = xd_grant ? BUS_XDATA : (code_grant ? BUS_FETCH : BUS_IDLE);
		s_d.flash_en     = 1'b0;
		s_d.sram_en      = 1'b0;
		s_d.radio_en     = 1'b0;
		s_d.sfr_xen      = 1'b0;
		s_d.bus_unmapped = 1'b0;
		s_d.bus_we       = xd_grant & xd_we;
		s_d.bus_wdata    = xd_wdata;
		s_d.flash_addr   = {1'b0, a};
		s_d.sram_addr    = a[12:0];
		s_d.radio_addr   = a[6:0];
		s_d.sfr_xaddr    = mirror_sfr(a);
		s_d.sram_we      = xd_grant & xd_we;

		// bus side decode, one cycle of latency
		if (xd_grant | code_grant) begin
			if (is_code && !s_q.munif) begin
				if (a < BANK_LO) begin
					s_d.flash_en = 1'b1;
				end else if (is_small) begin
					s_d.bus_unmapped = 1'b1;
				end else begin
					s_d.flash_en   = 1'b1;
					s_d.flash_addr = {bank_eff, a[14:0]};
				end
			end else if (a < BANK_LO) begin
				// lower half fixed to bank zero
				s_d.flash_en = 1'b1;
			end else if (a <= FLASH_XD_TOP) begin
				if (is_small) begin
					s_d.bus_unmapped = 1'b1;
				end else if (is_code) begin
					// lower 24 KB of chosen bank
					s_d.flash_en   = 1'b1;
					s_d.flash_addr = {bank_eff, a[14:0]};
				end else begin
					s_d.flash_en = 1'b1;
				end
			end else if (a < SFR_MIR_LO) begin
				s_d.radio_en = 1'b1;
			end else if (in_sfr) begin
				s_d.sfr_xen      = ~core_hit;
				s_d.bus_unmapped = core_hit;
			end else begin
				s_d.sram_en = 1'b1;
			end
		end

		s_d.id_sram_en   = 1'b0;
		s_d.id_reject    = 1'b0;
		s_d.id_sram_addr = {IDATA_PAGE, id_addr};
		if (id_req) begin
			if (id_addr[7] && !id_indirect) begin
				s_d.id_reject = 1'b1;
			end else begin
				s_d.id_sram_en = 1'b1;
			end
		end

		// bit access needs low three bits clear
		s_d.sfr_bit_ok = sfr_req & sfr_bit & sfr_addr[7] & (sfr_addr[2:0] == 3'h0);

		// register writes through the direct space or the mirror
		wr_en   = 1'b0;
		wr_loc  = sfr_addr;
		wr_data = sfr_wdata;
		if (sfr_req && sfr_we && !sfr_bit) begin
			wr_en = 1'b1;
		end else if (xd_grant && xd_we && in_sfr) begin
			wr_en   = 1'b1;
			wr_loc  = mirror_sfr(a);
			wr_data = xd_wdata;
		end
		if (wr_en) begin
			if (wr_loc == SFR_BANKSEL) begin
				s_d.bank = wr_data[PRIM_LSB+:2];
			end else if (wr_loc == SFR_MEMCFG) begin
				s_d.bank  = wr_data[MIRR_LSB+:2];
				s_d.munif = wr_data[UNIF_BIT];
			end
		end

		// read back sees the shared bank bits in both fields
		s_d.sfr_rdata = 8'h00;
		if (sfr_req && !sfr_we) begin
			if (sfr_addr == SFR_BANKSEL) begin
				s_d.sfr_rdata[PRIM_LSB+:2] = s_q.bank;
			end else if (sfr_addr == SFR_MEMCFG) begin
				s_d.sfr_rdata[MIRR_LSB+:2] = s_q.bank;
				s_d.sfr_rdata[UNIF_BIT]    = s_q.munif;
			end
		end

		// lower half powered off in deep sleep
		s_d.sram_low_off  = sleep;
		s_d.sram_excl_off = sleep;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// reset restores the standard map and bank zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q       <= '0;
			s_q.bus   <= BUS_IDLE;
			s_q.munif <= UNIF_RST;
			s_q.bank  <= BANK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign fetch_active        = s_q.bus == BUS_FETCH;
	assign xdata_active        = s_q.bus == BUS_XDATA;
	assign flash_en            = s_q.flash_en;
	assign flash_addr          = s_q.flash_addr;
	assign sram_en             = s_q.sram_en;
	assign sram_we             = s_q.sram_we & s_q.sram_en;
	assign sram_addr           = s_q.sram_addr;
	assign radio_en            = s_q.radio_en;
	assign radio_addr          = s_q.radio_addr;
	assign sfr_xen             = s_q.sfr_xen;
	assign sfr_xaddr           = s_q.sfr_xaddr;
	assign bus_we              = s_q.bus_we;
	assign bus_wdata           = s_q.bus_wdata;
	assign bus_unmapped        = s_q.bus_unmapped;
	assign id_sram_en          = s_q.id_sram_en;
	assign id_sram_addr        = s_q.id_sram_addr;
	assign id_reject           = s_q.id_reject;
	assign sfr_bit_ok          = s_q.sfr_bit_ok;
	assign sfr_rdata           = s_q.sfr_rdata;
	assign unified_map_select  = s_q.munif;
	assign bank_select_primary = s_q.bank;
	assign bank_select_mirror  = s_q.bank;
	assign sram_low_off        = s_q.sram_low_off;
	assign sram_excl_off       = s_q.sram_excl_off;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_xd_sram;
		xd_grant && xd_addr >= SRAM_LO;
	endsequence
	sequence s_sram_hit;
		sram_en && !flash_en && sram_addr == $past(xd_addr[12:0]);
	endsequence

	property p_bus_excl;
		@(posedge clk_sys) disable iff (rst)
		!(code_grant && xd_grant) && !(fetch_active && xdata_active);
	endproperty
	a_bus_excl: assert property (p_bus_excl) else $error("fetch and data share bus");

	property p_std_no_sram;
		@(posedge clk_sys) disable iff (rst)
		code_grant && !unified_map_select && code_addr >= SRAM_LO |=> !sram_en;
	endproperty
	a_std_no_sram: assert property (p_std_no_sram) else $error("standard map hit sram");

	property p_xd_sram;
		@(posedge clk_sys) disable iff (rst)
		s_xd_sram |=> s_sram_hit;
	endproperty
	a_xd_sram: assert property (p_xd_sram) else $error("sram window missed");

	property p_radio;
		@(posedge clk_sys) disable iff (rst)
		xd_grant && xd_addr >= RADIO_LO && xd_addr < SFR_MIR_LO
		|=> radio_en && radio_addr == $past(xd_addr[6:0]);
	endproperty
	a_radio: assert property (p_radio) else $error("radio window missed");

	property p_core_hidden;
		@(posedge clk_sys) disable iff (rst)
		xd_grant && xd_addr >= SFR_MIR_LO && xd_addr < SRAM_LO
		|=> sfr_xen == !CORE_SFR_MASK[$past(xd_addr[6:0])];
	endproperty
	a_core_hidden: assert property (p_core_hidden) else $error("mirror decode wrong");

	property p_xd_fixed;
		@(posedge clk_sys) disable iff (rst)
		xd_grant && !s_q.opt[0] && xd_addr >= BANK_LO && xd_addr <= FLASH_XD_TOP
		|=> flash_en && flash_addr == {1'b0, $past(xd_addr)};
	endproperty
	a_xd_fixed: assert property (p_xd_fixed) else $error("external flash banked");

	property p_unif_top;
		@(posedge clk_sys) disable iff (rst)
		code_grant && unified_map_select && code_addr > FLASH_XD_TOP |=> !flash_en;
	endproperty
	a_unif_top: assert property (p_unif_top) else $error("flash above window");

	property p_bank_share;
		@(posedge clk_sys) disable iff (rst)
		sfr_req && sfr_we && !sfr_bit && sfr_addr == SFR_BANKSEL && !(xd_grant && xd_we)
		|=> bank_select_mirror == $past(sfr_wdata[1:0]) ##1 $stable(bank_select_mirror)
		    || $past(sfr_req) && $past(sfr_we) || $past(xd_grant);
	endproperty
	a_bank_share: assert property (p_bank_share) else $error("bank fields differ");

	property p_id_upper;
		@(posedge clk_sys) disable iff (rst)
		id_req && id_addr[7] && !id_indirect |=> id_reject && !id_sram_en;
	endproperty
	a_id_upper: assert property (p_id_upper) else $error("direct upper data accepted");

	property p_bit_ok;
		@(posedge clk_sys) disable iff (rst)
		sfr_req && sfr_bit && sfr_addr[7] |=> sfr_bit_ok == ($past(sfr_addr[2:0]) == 3'h0);
	endproperty
	a_bit_ok: assert property (p_bit_ok) else $error("bit access decode wrong");

	property p_banked_code;
		@(posedge clk_sys) disable iff (rst)
		code_grant && !xd_req && !unified_map_select && s_q.opt == 2'b10 && code_addr >= BANK_LO
		|=> flash_en && flash_addr == {$past(s_q.bank), $past(code_addr[14:0])};
	endproperty
	a_banked_code: assert property (p_banked_code) else $error("bank translation wrong");

	property p_sleep;
		@(posedge clk_sys) disable iff (rst)
		deep_sleep_level_two || deep_sleep_level_three |=> sram_low_off && sram_excl_off;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep retention wrong");
endmodule

// >>> tb/core_port_model.sv
// behavioural cpu fetch and data requester facing the mapper
`timescale 1ns/1ns
module core_port_model (
	input  wire logic        clk_sys,
	input  wire logic        code_grant,
	input  wire logic        xd_grant,
	output logic             code_req,
	output logic [15:0]      code_addr,
	output logic             xd_req,
	output logic             xd_we,
	output logic [15:0]      xd_addr,
	output logic [7:0]       xd_wdata
);
	// idle state at time zero
	initial begin
		code_req = 1'b0;
		code_addr = 16'h0000;
		xd_req = 1'b0;
		xd_we = 1'b0;
		xd_addr = 16'h0000;
		xd_wdata = 8'h00;
	end

	// --------------------------------------------------------
	// one request cycle, taken at the rising edge in the middle
	// --------------------------------------------------------
	// fetch and data share the bus
	task automatic access(input logic f, input logic x, input logic we,
		input logic [15:0] a, input logic [7:0] d, output logic [1:0] gnt);
		@(negedge clk_sys);
		code_req = f;
		code_addr = a;
		xd_req = x;
		xd_we = we;
		xd_addr = a;
		xd_wdata = d;
		@(negedge clk_sys);
		gnt = {xd_grant, code_grant};
		// released lines flip so stale values never look valid
		code_req = 1'b0;
		xd_req = 1'b0;
		xd_we = 1'b0;
		code_addr = ~code_addr;
		xd_addr = ~xd_addr;
		xd_wdata = ~xd_wdata;
	endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the memory space mapper
`timescale 1ns/1ns
module tb_top;
	import memory_map_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sml = 1'b0, lrg = 1'b1, ds2 = 1'b0, ds3 = 1'b0;
	logic code_req, xd_req, xd_we, code_grant, xd_grant;
	logic [1:0] g;
	logic [15:0] code_addr, xd_addr;
	logic [7:0] xd_wdata, sfr_addr = 8'h00, sfr_wdata = 8'h00, id_addr = 8'h00;
	logic id_req = 1'b0, id_ind = 1'b0, sfr_req = 1'b0, sfr_we = 1'b0, sfr_bit = 1'b0;
	logic fa, xa, fe, se, swe, re, sx, bwe, um, ise, irj, bok, uni, lo, ex;
	logic [16:0] faddr;
	logic [12:0] saddr, isaddr;
	logic [6:0] raddr;
	logic [7:0] sxaddr, bwd, rdata;
	logic [1:0] bp, bm;
	int miscompares = 0, n_checks = 0, cycles = 0;

	always #50 clk_sys = ~clk_sys;

	core_port_model u_core (.clk_sys(clk_sys), .code_grant(code_grant), .xd_grant(xd_grant),
		.code_req(code_req), .code_addr(code_addr), .xd_req(xd_req), .xd_we(xd_we),
		.xd_addr(xd_addr), .xd_wdata(xd_wdata));

	memory_space_mapper u_dut (.clk_sys(clk_sys), .rst(rst), .small_flash_option(sml),
		.large_flash_option(lrg), .deep_sleep_level_two(ds2), .deep_sleep_level_three(ds3),
		.code_req(code_req), .code_addr(code_addr), .xd_req(xd_req), .xd_we(xd_we),
		.xd_addr(xd_addr), .xd_wdata(xd_wdata), .id_req(id_req), .id_indirect(id_ind),
		.id_addr(id_addr), .sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_bit(sfr_bit),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .code_grant(code_grant),
		.xd_grant(xd_grant), .fetch_active(fa), .xdata_active(xa), .flash_en(fe),
		.flash_addr(faddr), .sram_en(se), .sram_we(swe), .sram_addr(saddr), .radio_en(re),
		.radio_addr(raddr), .sfr_xen(sx), .sfr_xaddr(sxaddr), .bus_we(bwe), .bus_wdata(bwd),
		.bus_unmapped(um), .id_sram_en(ise), .id_sram_addr(isaddr), .id_reject(irj),
		.sfr_bit_ok(bok), .sfr_rdata(rdata), .unified_map_select(uni),
		.bank_select_primary(bp), .bank_select_mirror(bm), .sram_low_off(lo),
		.sram_excl_off(ex));

	// --------------------------------------------------------
	// compare, report and bus helpers
	// --------------------------------------------------------
	task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard, the whole run needs about 65 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic sfr_op(input logic we, input logic b, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_req = 1'b1;
		sfr_we = we;
		sfr_bit = b;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge clk_sys);
		sfr_req = 1'b0;
		sfr_we = 1'b0;
	endtask

	task automatic id_op(input logic ind, input logic [7:0] a);
		@(negedge clk_sys);
		id_req = 1'b1;
		id_ind = ind;
		id_addr = a;
		@(negedge clk_sys);
		id_req = 1'b0;
	endtask

	task automatic xd(input logic we, input logic [15:0] a, input logic [7:0] d);
		u_core.access(1'b0, 1'b1, we, a, d, g);
	endtask

	task automatic fetch(input logic [15:0] a);
		u_core.access(1'b1, 1'b0, 1'b0, a, 8'h00, g);
	endtask

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_banks();
		chk(18'(uni), 18'h0, "unified after reset");
		sfr_op(1'b1, 1'b0, SFR_BANKSEL, 8'h03);
		chk(18'(bm), 18'h3, "mirror bank");
		sfr_op(1'b0, 1'b0, SFR_BANKSEL, 8'h00);
		chk(18'(rdata), 18'h03, "bank readback");
	endtask

	task automatic t_std_fetch();
		fetch(16'h9234);
		chk(18'(faddr), 18'h19234, "banked fetch");
		// a stray store flag during a fetch must never reach the bus
		u_core.access(1'b1, 1'b0, 1'b1, 16'h1234, 8'hA5, g);
		chk(18'(faddr), 18'h01234, "low fetch");
		chk(18'(bwe), 18'h0, "fetch never writes");
		fetch(16'hE010);
		chk(18'({se, fe}), 18'h1, "std map flash only");
		chk(18'(faddr), 18'h1E010, "std top fetch");
	endtask

	task automatic t_xdata();
		xd(1'b0, 16'h9000, 8'h00);
		chk(18'(faddr), 18'h09000, "xdata fixed flash");
		xd(1'b0, 16'hDEFF, 8'h00);
		chk(18'({fe, faddr}), 18'h2DEFF, "xdata flash top");
		xd(1'b1, 16'hE010, 8'h5A);
		chk(18'({se, swe, saddr}), 18'h6010, "sram write");
		chk(18'({bwe, bwd}), 18'h15A, "write data");
		xd(1'b0, 16'hDF05, 8'h00);
		chk(18'({re, raddr}), 18'h85, "radio window");
		xd(1'b0, 16'hDF9F, 8'h00);
		chk(18'({sx, sxaddr}), 18'h19F, "register mirror");
		xd(1'b0, 16'hDF81, 8'h00);
		chk(18'({sx, um}), 18'h1, "core register hidden");
		xd(1'b0, 16'hFF85, 8'h00);
		chk(18'(saddr), 18'h1F85, "data page via xdata");
	endtask

	task automatic t_arbitrate();
		u_core.access(1'b1, 1'b1, 1'b0, 16'hE020, 8'h00, g);
		chk(18'(g), 18'h2, "fetch held off");
		chk(18'({fa, xa}), 18'h1, "data owns bus");
	endtask

	task automatic t_unified();
		sfr_op(1'b1, 1'b0, SFR_MEMCFG, 8'h60);
		chk(18'({uni, bp, bm}), 18'h1A, "unified and bank two");
		fetch(16'h9000);
		chk(18'(faddr), 18'h11000, "unified banked");
		fetch(16'hDEFF);
		chk(18'(faddr), 18'h15EFF, "unified top flash");
		fetch(16'hF000);
		chk(18'(fe), 18'h0, "no flash above window");
		chk(18'({se, saddr}), 18'h3000, "fetch from sram");
		sfr_op(1'b0, 1'b0, SFR_MEMCFG, 8'h00);
		chk(18'(rdata), 18'h60, "config readback");
	endtask

	task automatic t_idata();
		id_op(1'b0, 8'h05);
		chk(18'({ise, isaddr}), 18'h3F05, "direct low");
		id_op(1'b0, 8'h85);
		chk(18'({ise, irj}), 18'h1, "direct high refused");
		id_op(1'b1, 8'h85);
		chk(18'({ise, irj, isaddr}), 18'h5F85, "indirect high");
	endtask

	task automatic t_bits_sleep();
		sfr_op(1'b0, 1'b1, 8'h88, 8'h00);
		chk(18'(bok), 18'h1, "bit access on eight");
		sfr_op(1'b0, 1'b1, 8'h89, 8'h00);
		chk(18'(bok), 18'h0, "bit access off eight");
		@(negedge clk_sys);
		ds3 = 1'b1;
		@(negedge clk_sys);
		chk(18'({lo, ex}), 18'h3, "deep sleep loss");
		ds3 = 1'b0;
		ds2 = 1'b1;
		@(negedge clk_sys);
		chk(18'({lo, ex}), 18'h3, "level two loss");
		ds2 = 1'b0;
		@(negedge clk_sys);
		chk(18'({lo, ex}), 18'h0, "awake");
	endtask

	task automatic t_small();
		@(negedge clk_sys);
		rst = 1'b1;
		sml = 1'b1;
		lrg = 1'b0;
		@(negedge clk_sys);
		rst = 1'b0;
		chk(18'({uni, bp}), 18'h0, "second reset");
		repeat (3) @(negedge clk_sys);
		xd(1'b0, 16'h7FFF, 8'h00);
		chk(18'({fe, faddr}), 18'h27FFF, "small flash top");
		xd(1'b0, 16'h9000, 8'h00);
		chk(18'({fe, um}), 18'h1, "small flash hole");
	endtask

	// main sequence
	initial begin
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		t_banks();
		t_std_fetch();
		t_xdata();
		t_arbitrate();
		t_unified();
		t_idata();
		t_bits_sleep();
		t_small();
		summarize();
	end
endmodule
